/* rtl/ipdc_pkg.sv */
// constants and types shared by the idle and power-down controller
package ipdc_pkg;
    // core clock
    localparam int CLK_PERIOD_NS     = 40;
    // clocks per machine cycle of the core
    localparam int MACH_CYCLE_CLKS   = 12;
    // machine cycles the core may run on after a reset ends idle
    localparam int GRACE_MACH_CYCLES = 2;
    // self-timed wake delay from the falling edge of a wake pin
    localparam int WAKE_DELAY_NS     = 2000000;
    localparam int WAKE_DELAY_CYC    = WAKE_DELAY_NS / CLK_PERIOD_NS;
    // spacing software keeps before asking for power-down again
    localparam int REENTRY_NS        = 4000;
    localparam int REENTRY_CYC       = REENTRY_NS / CLK_PERIOD_NS;
    localparam int CNT_W             = 16;
    // reset values
    localparam logic REQ_RST         = 1'b0;
    localparam logic STROBE_RST      = 1'b1;

    typedef enum logic [2:0] {
        IPDC_RUN,
        IPDC_IDLE,
        IPDC_GRACE,
        IPDC_PDOWN,
        IPDC_WAKE,
        IPDC_RESET
    } ipdc_state_t;
endpackage

/* rtl/ipdc_top.sv */
// idle and power-down mode sequencer for an 8-bit core
//
// Behaviour
// [R01] an idle request halts the cpu while every peripheral keeps running.
// [R02] while idle, ram and special function registers stay unchanged.
// [R03] any enabled interrupt or a hardware reset ends idle.
// [R04] reset ending idle lets the core run two machine cycles, ram blocked.
// [R05] software makes no port or external write right after entering idle.
// [R06] strobes 1 in idle, 0 in power-down; port 0 floats, port 2 addresses (port2_addr_sel is set in idle only, never in power-down).
// [R07] power-down stops the oscillator after the requesting instruction.
// [R08] ram and special function registers keep their values in power-down.
// [R09] only a hardware reset or an enabled external pin ends power-down.
// [R10] reset from power-down clears special function registers, not ram.
// [R11] the reset source waits for good supply and holds through settling.
// [R12] a waking source holds its pin low for the oscillator start-up time.
// [R13] with timing select set, wake on rising edge, else a delay after fall.
// [R14] software waits the minimum time before re-entering power-down.
// [R15] one bit requests idle, one power-down, each at its instruction end.
// [R16] an exit by interrupt clears the mode request bit.
`timescale 1ns/1ps
module ipdc_top
    import ipdc_pkg::*;
#(
    parameter int MACH_CLKS  = ipdc_pkg::MACH_CYCLE_CLKS,
    parameter int WAKE_DELAY = ipdc_pkg::WAKE_DELAY_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // from the cpu
    input  wire logic idle_req_wr,
    input  wire logic pd_req_wr,
    input  wire logic instr_end,
    input  wire logic irq_any,
    input  wire logic ext_int_en_a,
    input  wire logic ext_int_en_b,
    input  wire logic wake_timing_select,
    input  wire logic ext_prog_mem,
    input  wire logic cpu_ale,
    input  wire logic cpu_prog_strobe,
    // pins
    input  wire logic ext_wake_pin_a,
    input  wire logic ext_wake_pin_b,
    input  wire logic hw_reset_pin,
    // control of the core
    output logic      cpu_halt,
    output logic      osc_stop,
    output logic      ram_block,
    output logic      core_reset,
    output logic      isr_start,
    output logic      idle_bit,
    output logic      pd_bit,
    // pin control
    output logic      ale_out,
    output logic      program_store_strobe,
    output logic      port0_float,
    output logic      port2_addr_sel
);
    import ipdc_pkg::*;

    localparam int GRACE = GRACE_MACH_CYCLES * MACH_CLKS;

    logic [2:0]       sync1_reg, sync2_reg;
    logic             pin_a_s, pin_b_s, hw_rst_s;
    ipdc_state_t      state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic             idle_reg, idle_next, pd_reg, pd_next;
    logic             halt_next, osc_next, ramb_next, crst_next, isr_next;
    logic             ale_next, pss_next, p0f_next, p2a_next;
    logic             wake_low, idle_eff, pd_eff, pins_high;

    // pins cross from outside the clock domain
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else begin
            sync1_reg <= {hw_reset_pin, ext_wake_pin_b, ext_wake_pin_a};
            sync2_reg <= sync1_reg;
        end
    end
    assign pin_a_s   = sync2_reg[0];
    assign pin_b_s   = sync2_reg[1];
    assign hw_rst_s  = sync2_reg[2];
    assign wake_low  = (ext_int_en_a && !pin_a_s) || (ext_int_en_b && !pin_b_s);
    assign pins_high = !((ext_int_en_a && !pin_a_s) ||
                         (ext_int_en_b && !pin_b_s));
    // a request written by the ending instruction counts at once
    assign idle_eff  = idle_reg || idle_req_wr; // see [R15]
    assign pd_eff    = pd_reg || pd_req_wr; // see [R15]

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        idle_next  = idle_eff;
        pd_next    = pd_eff;
        isr_next   = 1'b0;
        case (state_reg)
            IPDC_RUN: begin
                if (hw_rst_s) begin
                    state_next = IPDC_RESET;
                end else if (instr_end && pd_eff) begin
                    state_next = IPDC_PDOWN; // see [R07]
                end else if (instr_end && idle_eff) begin
                    state_next = IPDC_IDLE; // see [R01]
                end
            end
            IPDC_IDLE: begin
                if (hw_rst_s) begin
                    state_next = IPDC_GRACE; // see [R04]
                    cnt_next   = '0;
                end else if (irq_any) begin
                    state_next = IPDC_RUN; // see [R03]
                    idle_next  = 1'b0; // see [R16]
                end
            end
            IPDC_GRACE: begin
                // the core runs on briefly; ram writes are held off
                if (cnt_reg == CNT_W'(GRACE - 1)) begin
                    state_next = IPDC_RESET; // see [R04]
                end else begin
                    cnt_next = cnt_reg + CNT_W'(1);
                end
            end
            IPDC_PDOWN: begin
                if (hw_rst_s) begin
                    state_next = IPDC_RESET; // see [R10]
                    // bits read as reset from the first reset cycle on
                    idle_next  = REQ_RST;
                    pd_next    = REQ_RST;
                end else if (wake_low) begin
                    state_next = IPDC_WAKE; // see [R09]
                    cnt_next   = '0;
                end
            end
            IPDC_WAKE: begin
                if (hw_rst_s) begin
                    state_next = IPDC_RESET;
                end else if (wake_timing_select ? pins_high
                        : (cnt_reg == CNT_W'(WAKE_DELAY - 1))) begin
                    state_next = IPDC_RUN; // see [R13]
                    isr_next   = 1'b1;
                    pd_next    = 1'b0; // see [R16]
                end else if (!wake_timing_select) begin
                    cnt_next = cnt_reg + CNT_W'(1);
                end
            end
            IPDC_RESET: begin
                // reset reinitialises the control bits, ram is not touched
                idle_next = REQ_RST;
                pd_next   = REQ_RST;
                if (!hw_rst_s) begin
                    state_next = IPDC_RUN;
                end
            end
            default: begin
                state_next = IPDC_RUN;
            end
        endcase
    end

    // pin and core controls follow the next state
    always_comb begin
        halt_next = 1'b0;
        osc_next  = 1'b0;
        ramb_next = 1'b0;
        crst_next = 1'b0;
        ale_next  = cpu_ale;
        pss_next  = cpu_prog_strobe;
        p0f_next  = 1'b0;
        p2a_next  = 1'b0;
        case (state_next)
            IPDC_IDLE: begin
                halt_next = 1'b1; // see [R01] [R02]
                ale_next  = 1'b1; // see [R06]
                pss_next  = 1'b1;
                p0f_next  = ext_prog_mem;
                p2a_next  = ext_prog_mem;
            end
            IPDC_GRACE: begin
                ramb_next = 1'b1; // see [R04]
            end
            IPDC_PDOWN, IPDC_WAKE: begin
                // wake state keeps pins parked until the routine starts
                halt_next = 1'b1;
                osc_next  = (state_next == IPDC_PDOWN); // see [R07]
                ramb_next = 1'b1; // see [R08]
                ale_next  = 1'b0; // see [R06]
                pss_next  = 1'b0;
                p0f_next  = ext_prog_mem;
            end
            IPDC_RESET: begin
                crst_next = 1'b1; // see [R10]
                ramb_next = 1'b1;
            end
            default: begin
                halt_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg            <= IPDC_RUN;
            cnt_reg              <= '0;
            idle_reg             <= REQ_RST;
            pd_reg               <= REQ_RST;
            cpu_halt             <= 1'b0;
            osc_stop             <= 1'b0;
            ram_block            <= 1'b0;
            core_reset           <= 1'b0;
            isr_start            <= 1'b0;
            ale_out              <= STROBE_RST;
            program_store_strobe <= STROBE_RST;
            port0_float          <= 1'b0;
            port2_addr_sel       <= 1'b0;
        end else begin
            state_reg            <= state_next;
            cnt_reg              <= cnt_next;
            idle_reg             <= idle_next;
            pd_reg               <= pd_next;
            cpu_halt             <= halt_next;
            osc_stop             <= osc_next;
            ram_block            <= ramb_next;
            core_reset           <= crst_next;
            isr_start            <= isr_next;
            ale_out              <= ale_next;
            program_store_strobe <= pss_next;
            port0_float          <= p0f_next;
            port2_addr_sel       <= p2a_next;
        end
    end
    assign idle_bit = idle_reg;
    assign pd_bit   = pd_reg;

    a_idle_halt: assert property (@(posedge clk) // see [R01]
        disable iff (!rst_n)
        state_reg == IPDC_IDLE |-> cpu_halt && !osc_stop && !ram_block)
        else $error("idle must halt cpu with clock running");
    a_idle_pins: assert property (@(posedge clk) // see [R06]
        disable iff (!rst_n)
        state_reg == IPDC_IDLE |-> ale_out && program_store_strobe
            && port2_addr_sel == ext_prog_mem)
        else $error("idle strobes not high");
    a_pd_pins: assert property (@(posedge clk) // see [R06]
        disable iff (!rst_n)
        state_reg == IPDC_PDOWN |-> !ale_out && !program_store_strobe
            && osc_stop && ram_block)
        else $error("power-down pins or oscillator wrong");
    a_pd_entry: assert property (@(posedge clk) // see [R07]
        disable iff (!rst_n)
        $rose(osc_stop) |-> $past(instr_end) && $past(pd_eff))
        else $error("power-down entered outside instruction end");
    a_idle_wake: assert property (@(posedge clk) // see [R03]
        disable iff (!rst_n)
        state_reg == IPDC_IDLE && irq_any && !hw_rst_s
            |=> !cpu_halt && !idle_bit)
        else $error("enabled interrupt did not end idle");
    a_grace_len: assert property (@(posedge clk) // see [R04]
        disable iff (!rst_n)
        state_reg == IPDC_IDLE && hw_rst_s
            |=> ram_block && !cpu_halt ##[23:24] core_reset)
        else $error("reset grace after idle wrong");
    a_pd_hold: assert property (@(posedge clk) // see [R09]
        disable iff (!rst_n)
        state_reg == IPDC_PDOWN && !wake_low && !hw_rst_s
            |=> state_reg == IPDC_PDOWN)
        else $error("power-down left without wake source");
    a_pd_reset: assert property (@(posedge clk) // see [R10]
        disable iff (!rst_n)
        state_reg == IPDC_PDOWN && hw_rst_s
            |=> core_reset && ram_block && !pd_bit)
        else $error("reset from power-down wrong");
    a_edge_wake: assert property (@(posedge clk) // see [R13]
        disable iff (!rst_n)
        state_reg == IPDC_WAKE && wake_timing_select && !hw_rst_s
            && pins_high |=> isr_start && !pd_bit && !cpu_halt)
        else $error("rising edge wake did not start routine");
    a_timed_wake: assert property (@(posedge clk) // see [R13]
        disable iff (!rst_n)
        isr_start && !$past(wake_timing_select)
            |-> $past(cnt_reg) == CNT_W'(WAKE_DELAY - 1))
        else $error("timed wake delay wrong");
endmodule // ipdc_top

/* verification/ipdc_tb_top.sv */
// self-checking bench for the idle and power-down controller
`timescale 1ns/1ps
module ipdc_tb_top;
    import ipdc_pkg::*;
    localparam int MC = 12;
    localparam int WD = 20;
    localparam int HALT = 10, OSC = 9, RAM = 8, CRST = 7, ISR = 6;
    typedef struct {string nm; logic [10:0] m; logic [10:0] v;} ipdc_note_t;
    logic clk = 0;
    logic rst_n, idle_req_wr, pd_req_wr, instr_end, irq_any, ext_int_en_a;
    logic ext_int_en_b, wake_timing_select, ext_prog_mem, cpu_ale;
    logic cpu_prog_strobe, wake_a_req, wake_b_req, reset_req;
    logic ext_wake_pin_a, ext_wake_pin_b, hw_reset_pin;
    logic cpu_halt, osc_stop, ram_block, core_reset, isr_start, idle_bit;
    logic pd_bit, ale_out, program_store_strobe, port0_float, port2_addr_sel;
    logic [10:0] snap;
    logic [10:0] xpm;
    logic [31:0] rnd = 32'h6D46;
    ipdc_note_t  q[$];
    ipdc_note_t  e;
    int          miscompares = 0;
    int          n_checks = 0;
    int          k;
    event        go;
    assign snap = {cpu_halt, osc_stop, ram_block, core_reset, isr_start,
                   idle_bit, pd_bit, ale_out, program_store_strobe,
                   port0_float, port2_addr_sel};
    ipdc_top #(.MACH_CLKS(MC), .WAKE_DELAY(WD)) i_ipdc_top (
        .clk, .rst_n, .idle_req_wr, .pd_req_wr, .instr_end, .irq_any,
        .ext_int_en_a, .ext_int_en_b, .wake_timing_select, .ext_prog_mem,
        .cpu_ale, .cpu_prog_strobe, .ext_wake_pin_a, .ext_wake_pin_b,
        .hw_reset_pin, .cpu_halt, .osc_stop, .ram_block, .core_reset,
        .isr_start, .idle_bit, .pd_bit, .ale_out, .program_store_strobe,
        .port0_float, .port2_addr_sel);
    ipdc_wake_model i_ipdc_wake_model (
        .clk, .wake_a_req, .wake_b_req, .reset_req, .pin_a(ext_wake_pin_a),
        .pin_b(ext_wake_pin_b), .rst_pin(hw_reset_pin));
    initial begin
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(string nm, logic [10:0] seen, logic [10:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic ex(string nm, logic [10:0] m, logic [10:0] v);
        q.push_back('{nm, m, v});
        ->go;
        #1;
    endtask
    // the watcher compares each note against the outputs it is woken for
    always @(go) begin
        while (q.size() > 0) begin
            e = q.pop_front();
            check(e.nm, snap & e.m, e.v & e.m);
        end
    end
    task automatic summarize();
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wt(int b, logic v, int lim, output int n);
        n = 0;
        while (snap[b] !== v) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                miscompares++;
                summarize();
            end
        end
    endtask
    task automatic req(logic idl, logic pd);
        idle_req_wr = idl;
        pd_req_wr = pd;
        instr_end = 1;
        @(negedge clk);
        {idle_req_wr, pd_req_wr, instr_end} = 3'h0;
    endtask
    initial begin
        {rst_n, idle_req_wr, pd_req_wr, instr_end, irq_any} = 5'h00;
        {wake_timing_select, ext_prog_mem, cpu_ale, cpu_prog_strobe} = 4'h0;
        {wake_a_req, wake_b_req, reset_req, ext_int_en_b} = 4'h0;
        ext_int_en_a = 1;
        repeat (5) @(negedge clk);
        // once running the strobes follow the core, so look while in reset
        ex("reset state", 11'h7FF, 11'h00C);
        rst_n = 1;
        @(negedge clk);
        repeat (6) begin
            rnd = lfsr(rnd);
            {cpu_ale, cpu_prog_strobe, ext_prog_mem} = rnd[2:0];
            @(negedge clk);
            ex("strobes", 11'h00C, {7'h00, rnd[2:1], 2'h0});
        end
        xpm = {9'h000, rnd[0], rnd[0]};
        idle_req_wr = 1;
        @(negedge clk);
        idle_req_wr = 0;
        ex("bit only", 11'h420, 11'h020);
        req(0, 0);
        ex("idle", 11'h7FF, 11'h42C | xpm);
        repeat (5) @(negedge clk);
        ex("idle held", 11'h7FF, 11'h42C | xpm);
        irq_any = 1;
        @(negedge clk);
        irq_any = 0;
        ex("idle exit", 11'h620, 11'h000);
        repeat (REENTRY_CYC) @(negedge clk);
        req(1, 1);
        ex("pdown", 11'h7DF, 11'h710 | (xpm & 11'h002));
        irq_any = 1;
        wake_b_req = 1;
        repeat (6) @(negedge clk);
        {irq_any, wake_b_req} = 2'h0;
        ex("pd refuse", 11'h710, 11'h710);
        wake_timing_select = 1;
        wake_a_req = 1;
        wt(OSC, 0, 10, k);
        repeat (4) @(negedge clk);
        ex("pin low", 11'h5DC, 11'h510);
        wake_a_req = 0;
        wt(ISR, 1, 20, k);
        ex("edge wake", 11'h450, 11'h040);
        @(negedge clk);
        ex("isr pulse", 11'h040, 11'h000);
        repeat (REENTRY_CYC) @(negedge clk);
        {ext_int_en_b, wake_timing_select} = 2'h2;
        req(0, 1);
        wake_b_req = 1;
        wt(OSC, 0, 10, k);
        wt(ISR, 1, 60, k);
        wake_b_req = 0;
        check("timed wake", 11'(k >= WD-2 && k <= WD+1), 11'h001);
        repeat (10) @(negedge clk);
        req(1, 0);
        reset_req = 1;
        wt(RAM, 1, 8, k);
        ex("grace", 11'h580, 11'h100);
        wt(CRST, 1, 40, k);
        check("grace len", 11'(k), 11'(2 * MC));
        reset_req = 0;
        wt(CRST, 0, 10, k);
        ex("idle reset", 11'h720, 11'h000);
        repeat (REENTRY_CYC) @(negedge clk);
        req(0, 1);
        reset_req = 1;
        wt(CRST, 1, 10, k);
        ex("pd reset", 11'h190, 11'h180);
        reset_req = 0;
        wt(CRST, 0, 10, k);
        ex("pd reset exit", 11'h610, 11'h000);
        summarize();
    end
endmodule // ipdc_tb_top

/* verification/ipdc_wake_model.sv */
// behavioural wake pin and hardware reset source outside the core
`timescale 1ns/1ps
module ipdc_wake_model #(
    parameter int MIN_LOW = 4
) (
    // clock
    input  wire logic clk,
    // commands from the bench
    input  wire logic wake_a_req,
    input  wire logic wake_b_req,
    input  wire logic reset_req,
    // pins
    output logic      pin_a,
    output logic      pin_b,
    output logic      rst_pin
);
    int cnt_a = 0;
    int cnt_b = 0;
    // a wake pulse is stretched to cover oscillator start-up
    always @(posedge clk) begin
        if (wake_a_req) begin
            cnt_a <= MIN_LOW;
        end else if (cnt_a > 0) begin
            cnt_a <= cnt_a - 1;
        end
        if (wake_b_req) begin
            cnt_b <= MIN_LOW;
        end else if (cnt_b > 0) begin
            cnt_b <= cnt_b - 1;
        end
    end
    // pins are pulled up, so a released pin reads high
    assign pin_a = !(wake_a_req || cnt_a > 0);
    assign pin_b = !(wake_b_req || cnt_b > 0);
    // raised only once supply is good, held by the bench past settling
    assign rst_pin = reset_req;
endmodule // ipdc_wake_model
